/* File: mcu_instruction_decode_timing_tb.sv */
// self-checking bench for the decode and timing core
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module mcu_instruction_decode_timing_tb;
    logic mclk = 0; // 50 MHz clock
    logic rst_n = 0; // synchronous reset
    logic [9:0] instr_addr;
    logic [12:0] instr_data;
    logic [7:0] port5_out;
    logic [7:0] port6_out;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 0;
    logic avs_write = 0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    int fails = 0; // mismatches
    int checked = 0; // comparisons
    int cyc = 0; // cycle count for timeout and timing
    logic [31:0] q;
    int t1;
    int t2;
    int ec;
    logic [9:0] held;
    always #10 mclk = ~mclk;
    mdt_core i_dut (.mclk(mclk), .rst_n(rst_n), .instr_addr(instr_addr), .instr_data(instr_data),
        .port5_out(port5_out), .port6_out(port6_out), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    mdt_prog_mem i_mem (.instr_addr(instr_addr), .instr_data(instr_data));
    // verdict and end of run
    task finish_test();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1; // non-blocking so stamps taken at an edge are race free
        if (cyc >= 5000) begin
            fails++;
            finish_test();
        end
    end
    // one avalon transfer, held until waitrequest is sampled low
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        q = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
        @(posedge mclk);
    endtask
    // cycle stamp at which the fetch address reaches a value
    task wait_pc(input logic [9:0] a, output int t);
        while (instr_addr !== a) @(posedge mclk);
        t = cyc;
    endtask
    // main sequence: the program in two-clock then four-clock mode
    initial begin
        for (int m = 0; m < 2; m++) begin
            ec = m ? 4 : 2;
            rst_n <= 0;
            repeat (20) @(posedge mclk);
            rst_n <= 1;
            @(posedge mclk);
            bus(1, mdt_pkg::OFS_CTRL, m ? 32'h0000_0003 : 32'h0000_0001);
            wait_pc(10'h001, t1);
            wait_pc(10'h002, t2);
            `CHK(t2 - t1, ec)
            wait_pc(10'h005, t1);
            wait_pc(10'h009, t2);
            `CHK(t2 - t1, 3 * ec)
            wait_pc(10'h00A, t1);
            repeat (4 * ec) @(posedge mclk);
            held = instr_addr;
            repeat (20) @(posedge mclk);
            `CHK(instr_addr, held)
            `CHK(port5_out, 8'h5A)
            `CHK(port6_out, 8'h08)
            bus(0, mdt_pkg::OFS_STATUS, 32'h0000_0000);
            `CHK(q, 32'h0000_0077)
            bus(0, mdt_pkg::OFS_ACC, 32'h0000_0000);
            `CHK(q, 32'h0000_0000)
            bus(0, mdt_pkg::OFS_PC, 32'h0000_0000);
            `CHK(q[9:0], 10'h00B)
            bus(0, mdt_pkg::OFS_TIMER, 32'h0000_0000);
            `CHK(q, 32'h0000_000C)
            bus(1, 5'h1C, 32'h0000_00FF);
            bus(0, 5'h1C, 32'h0000_0000);
            `CHK(q, 32'h0000_0000)
        end
        finish_test();
    end
endmodule

/* File: mdt_alu.sv */
// eight-bit alu with zero, carry and half-carry results
`timescale 1ns/10ps
module mdt_alu (
    // operands
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire mdt_pkg::mdt_aop_t op,
    // results
    output logic [7:0] y,
    output logic cy,
    output logic hc,
    output logic zf
);
    logic [8:0] sum9; // nine-bit sum for carry
    logic [8:0] dif9; // nine-bit difference for borrow
    logic [4:0] sumlo; // low nibble sum
    // arithmetic helpers
    always_comb begin
        sum9 = {1'b0, b} + {1'b0, a};
        dif9 = {1'b0, b} - {1'b0, a};
        sumlo = {1'b0, b[3:0]} + {1'b0, a[3:0]};
    end
    // operation select; subtraction is b minus a
    always_comb begin
        y = 8'h00;
        cy = 1'b0;
        hc = 1'b0;
        unique case (op)
            mdt_pkg::MDT_AOP_PASS_A: y = a;
            mdt_pkg::MDT_AOP_PASS_B: y = b;
            mdt_pkg::MDT_AOP_ZERO: y = 8'h00;
            mdt_pkg::MDT_AOP_OR: y = a | b;
            mdt_pkg::MDT_AOP_AND: y = a & b;
            mdt_pkg::MDT_AOP_XOR: y = a ^ b;
            mdt_pkg::MDT_AOP_ADD: begin
                y = sum9[7:0];
                cy = sum9[8];
                hc = sumlo[4];
            end
            mdt_pkg::MDT_AOP_SUB: begin
                y = dif9[7:0];
                cy = ~dif9[8];
                hc = (b[3:0] >= a[3:0]);
            end
            mdt_pkg::MDT_AOP_DEC: y = b - 8'h01;
            default: y = 8'h00;
        endcase
        zf = (y == 8'h00);
    end
endmodule

/* File: mdt_core.sv */
// instruction decode, cycle timing, register file and avalon slave
//
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
module mdt_core (
    // clock and synchronous reset
    input wire logic mclk,
    input wire logic rst_n,
    // program memory fetch
    output logic [9:0] instr_addr,
    input wire logic [12:0] instr_data,
    // port registers driven out
    output logic [7:0] port5_out,
    output logic [7:0] port6_out,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    // depths taken from the package, declared before the arrays that use them
    localparam int FILE_D = mdt_pkg::FILE_D;
    localparam int STACK_D = mdt_pkg::STACK_D;
    // core state
    logic [9:0] pc_q; // program counter
    logic [7:0] acc_q; // accumulator
    logic [7:0] timer_q; // timer_count_register
    logic [7:0] bank_q; // bank_select_reg
    logic [7:0] wdt_q; // watchdog_count
    logic c_q, dc_q, z_q, pd_q, to_q; // status flags
    logic gie_q; // global interrupt enable
    logic sleep_q; // oscillator stopped
    logic pen_q; // penalty cycle after pc write
    logic [1:0] ph_q; // oscillator phase within a cycle
    logic [1:0] ctrl_q; // run and cycle-length option
    logic [7:0] file_q [FILE_D];
    logic [7:0] io_control_reg_q [16]; // io_control_reg slots
    logic [9:0] stack_q [STACK_D]; // return stack
    logic [2:0] sp_q; // stack pointer
    logic wait_q; // bus wait state
    logic [31:0] rdata_q; // bus read data

    // decode results
    logic [12:0] ins; // current instruction word
    logic [5:0] ra; // register operand
    logic [2:0] bsel; // bit selector
    logic [7:0] k8; // short literal
    logic [9:0] k10; // long literal
    mdt_pkg::mdt_aop_t aop;
    logic use_k, wr_a, wr_r, upd_z, upd_cdc;
    logic bit_wr, bit_set, bit_tst, bit_want;
    logic do_sleep, do_wdtc, do_iow, do_ior, do_on, do_off;
    logic do_ret, do_return_from_interrupt_instr, do_call, do_jmp, do_bank;
    // datapath
    logic [6:0] ridx; // banked file index
    logic [7:0] rval; // register operand value
    logic [7:0] alu_y, wdata;
    logic alu_c, alu_hc, alu_z;
    logic [7:0] bmask; // selected bit mask
    logic tick, exec, skip, ctl_ok;
    logic [1:0] ph_last;

    assign ins = instr_data;
    assign ra = ins[5:0];
    assign bsel = ins[8:6];
    assign k8 = ins[7:0];
    assign k10 = ins[9:0];

    // instruction cycle timing: last phase is 1 or 3
    always_comb begin
        ph_last = ctrl_q[mdt_pkg::CTRL_CLK4] ? mdt_pkg::PH_LAST_4 : mdt_pkg::PH_LAST_2;
        tick = ctrl_q[mdt_pkg::CTRL_RUN] & ~sleep_q & (ph_q == ph_last);
        exec = tick & ~pen_q;
    end

    // phase counter runs only while the oscillator runs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ph_q <= 2'h0;
        end else if (!ctrl_q[mdt_pkg::CTRL_RUN] || sleep_q || tick) begin
            ph_q <= 2'h0;
        end else begin
            ph_q <= ph_q + 2'h1;
        end
    end

    // instruction decode
    always_comb begin
        aop = mdt_pkg::MDT_AOP_PASS_A;
        use_k = 1'b0;
        wr_a = 1'b0;
        wr_r = 1'b0;
        upd_z = 1'b0;
        upd_cdc = 1'b0;
        bit_wr = 1'b0;
        bit_set = 1'b0;
        bit_tst = 1'b0;
        bit_want = 1'b0;
        do_sleep = 1'b0;
        do_wdtc = 1'b0;
        do_iow = 1'b0;
        do_ior = 1'b0;
        do_on = 1'b0;
        do_off = 1'b0;
        do_ret = 1'b0;
        do_return_from_interrupt_instr = 1'b0;
        do_call = 1'b0;
        do_jmp = 1'b0;
        do_bank = 1'b0;
        if (!ins[12]) begin
            if (ins[11]) begin
                // bit clear, set and tests
                bit_wr = ~ins[10];
                bit_set = ins[9];
                bit_tst = ins[10];
                bit_want = ins[9];
            end else if (!ins[10]) begin
                unique case (ins[9:6])
                    4'b0000: begin
                        // control group
                        if (ra == mdt_pkg::CI_SLEEP) begin
                            do_sleep = 1'b1;
                        end else if (ra == mdt_pkg::CI_WDTC) begin
                            do_wdtc = 1'b1;
                        end else if (ra >= mdt_pkg::CI_CTRL_WR_FIRST && ra < mdt_pkg::CI_IRQ_ON) begin
                            do_iow = 1'b1;
                        end else if (ra == mdt_pkg::CI_IRQ_ON) begin
                            do_on = 1'b1;
                        end else if (ra == mdt_pkg::CI_IRQ_OFF) begin
                            do_off = 1'b1;
                        end else if (ra == mdt_pkg::CI_RET) begin
                            do_ret = 1'b1;
                        end else if (ra == mdt_pkg::CI_RETURN_FROM_INTERRUPT_INSTR) begin
                            do_return_from_interrupt_instr = 1'b1;
                        end else if (ra >= mdt_pkg::CI_CTRL_RD_FIRST && ra < 6'h20) begin
                            do_ior = 1'b1;
                        end
                    end
                    4'b0001: begin
                        wr_r = 1'b1; // move accumulator to register
                    end
                    4'b0010: begin
                        if (ra == 6'h00) begin
                            aop = mdt_pkg::MDT_AOP_ZERO;
                            wr_a = 1'b1;
                            upd_z = 1'b1;
                        end
                    end
                    4'b0011: begin
                        aop = mdt_pkg::MDT_AOP_ZERO;
                        wr_r = 1'b1;
                        upd_z = 1'b1;
                    end
                    default: begin
                        // arithmetic and logic on a register; bit 6 picks destination
                        wr_a = ~ins[6];
                        wr_r = ins[6];
                        upd_z = 1'b1;
                        unique case (ins[9:7])
                            3'b010: begin
                                aop = mdt_pkg::MDT_AOP_SUB;
                                upd_cdc = 1'b1;
                            end
                            3'b011: aop = mdt_pkg::MDT_AOP_DEC;
                            3'b100: aop = mdt_pkg::MDT_AOP_OR;
                            3'b101: aop = mdt_pkg::MDT_AOP_AND;
                            3'b110: aop = mdt_pkg::MDT_AOP_XOR;
                            default: begin
                                aop = mdt_pkg::MDT_AOP_ADD;
                                upd_cdc = 1'b1;
                            end
                        endcase
                    end
                endcase
            end
        end else if (!ins[11]) begin
            // ten-bit literal jumps
            do_call = ~ins[10];
            do_jmp = ins[10];
        end else begin
            // eight-bit literal operations on the accumulator and the bank register
            use_k = 1'b1;
            wr_a = 1'b1;
            unique case (ins[10:8])
                3'b000: aop = mdt_pkg::MDT_AOP_PASS_B;
                3'b001: begin
                    aop = mdt_pkg::MDT_AOP_OR;
                    upd_z = 1'b1;
                end
                3'b010: begin
                    aop = mdt_pkg::MDT_AOP_AND;
                    upd_z = 1'b1;
                end
                3'b011: begin
                    aop = mdt_pkg::MDT_AOP_XOR;
                    upd_z = 1'b1;
                end
                3'b100: begin
                    aop = mdt_pkg::MDT_AOP_PASS_B;
                    do_ret = 1'b1;
                end
                3'b101: begin
                    aop = mdt_pkg::MDT_AOP_SUB;
                    upd_z = 1'b1;
                    upd_cdc = 1'b1;
                end
                3'b110: begin
                    wr_a = 1'b0;
                    do_bank = (ins[7:4] == mdt_pkg::BANK_SUBCODE);
                end
                default: begin
                    aop = mdt_pkg::MDT_AOP_ADD;
                    upd_z = 1'b1;
                    upd_cdc = 1'b1;
                end
            endcase
        end
    end

    // register operand fetch: low addresses are common, upper ones banked
    always_comb begin
        ridx = (ra < mdt_pkg::RA_BANKED_BASE) ? {1'b0, ra} : {bank_q[mdt_pkg::BANK_BIT], ra};
        unique case (ra)
            mdt_pkg::RA_INDIRECT: rval = 8'h00;
            mdt_pkg::RA_TIMER: rval = timer_q;
            mdt_pkg::RA_PC: rval = pc_q[7:0];
            mdt_pkg::RA_STATUS: rval = {3'b000, to_q, pd_q, z_q, dc_q, c_q};
            mdt_pkg::RA_BANK: rval = bank_q;
            default: rval = file_q[ridx];
        endcase
        bmask = 8'h01 << bsel;
        wdata = bit_wr ? (bit_set ? (rval | bmask) : (rval & ~bmask)) : alu_y;
        skip = bit_tst & (((rval & bmask) != 8'h00) == bit_want);
        ctl_ok = (ra[3:0] == 4'h5) || (ra[3:0] == 4'h6) || (ra[3:0] >= 4'hB);
    end

    mdt_alu u_alu (
        .a(acc_q),
        .b(use_k ? k8 : rval),
        .op(aop),
        .y(alu_y),
        .cy(alu_c),
        .hc(alu_hc),
        .zf(alu_z)
    );

    // general file, one entry per index; ports live here like any register
    for (genvar gi = 0; gi < FILE_D; gi++) begin : g_file
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                file_q[gi] <= 8'h00;
            end else if (exec && (wr_r || bit_wr) && ra > mdt_pkg::RA_BANK && ridx == 7'(gi)) begin
                file_q[gi] <= wdata;
            end
        end
    end

    // control register slots; unsupported slots are ignored
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                io_control_reg_q[i] <= 8'h00;
            end
        end else if (exec && do_iow && ctl_ok) begin
            io_control_reg_q[ra[3:0]] <= acc_q;
        end
    end

    // accumulator
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            acc_q <= 8'h00;
        end else if (exec && wr_a) begin
            acc_q <= alu_y;
        end else if (exec && do_ior && ctl_ok) begin
            acc_q <= io_control_reg_q[ra[3:0]];
        end
    end

    // status flags; flag results win over a direct write of the status register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            c_q <= 1'b0;
            dc_q <= 1'b0;
            z_q <= 1'b0;
            pd_q <= 1'b1;
            to_q <= 1'b1;
        end else if (exec) begin
            if ((wr_r || bit_wr) && ra == mdt_pkg::RA_STATUS) begin
                c_q <= wdata[mdt_pkg::ST_C];
                dc_q <= wdata[mdt_pkg::ST_DC];
                z_q <= wdata[mdt_pkg::ST_Z];
            end
            if (upd_z) begin
                z_q <= alu_z;
            end
            if (upd_cdc) begin
                c_q <= alu_c;
                dc_q <= alu_hc;
            end
            if (do_sleep) begin
                to_q <= 1'b1;
                pd_q <= 1'b0;
            end else if (do_wdtc) begin
                to_q <= 1'b1;
                pd_q <= 1'b1;
            end
        end
    end

    // timer counts instruction cycles, so it follows the two or four clock rate
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            timer_q <= 8'h00;
        end else if (exec && (wr_r || bit_wr) && ra == mdt_pkg::RA_TIMER) begin
            timer_q <= wdata;
        end else if (tick) begin
            timer_q <= timer_q + 8'h01;
        end
    end

    // watchdog counter, cleared by sleep and watchdog clear
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wdt_q <= 8'h00;
        end else if (exec && (do_sleep || do_wdtc)) begin
            wdt_q <= 8'h00;
        end else if (tick) begin
            wdt_q <= wdt_q + 8'h01;
        end
    end

    // bank select register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bank_q <= 8'h00;
        end else if (exec && do_bank) begin
            bank_q[mdt_pkg::BANK_BIT] <= k8[0];
        end else if (exec && (wr_r || bit_wr) && ra == mdt_pkg::RA_BANK) begin
            bank_q <= wdata;
        end
    end

    // global interrupt enable
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            gie_q <= 1'b0;
        end else if (exec && (do_on || do_return_from_interrupt_instr)) begin
            gie_q <= 1'b1;
        end else if (exec && do_off) begin
            gie_q <= 1'b0;
        end
    end

    // sleep stops the cycle clock until software wakes the core
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sleep_q <= 1'b0;
        end else if (exec && do_sleep) begin
            sleep_q <= 1'b1;
        end else if (!wait_q && avs_write && avs_address == mdt_pkg::OFS_WAKE && avs_byteenable[0]
                     && avs_writedata[0]) begin
            sleep_q <= 1'b0;
        end
    end

    // program counter, return stack and pc-write penalty
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pc_q <= 10'h000;
            sp_q <= 3'h0;
            pen_q <= 1'b0;
            for (int i = 0; i < STACK_D; i++) begin
                stack_q[i] <= 10'h000;
            end
        end else if (tick && pen_q) begin
            pen_q <= 1'b0;
        end else if (exec) begin
            if ((wr_r || bit_wr) && ra == mdt_pkg::RA_PC) begin
                pc_q <= {pc_q[9:8], wdata};
                pen_q <= 1'b1;
            end else if (do_call) begin
                stack_q[sp_q] <= pc_q + 10'h001;
                sp_q <= sp_q + 3'h1;
                pc_q <= k10;
            end else if (do_jmp) begin
                pc_q <= k10;
            end else if (do_ret || do_return_from_interrupt_instr) begin
                pc_q <= stack_q[sp_q - 3'h1];
                sp_q <= sp_q - 3'h1;
            end else if (skip) begin
                pc_q <= pc_q + 10'h002;
            end else begin
                pc_q <= pc_q + 10'h001;
            end
        end
    end

    // bus slave: one wait cycle, then the request completes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else if (wait_q && (avs_read || avs_write)) begin
            wait_q <= 1'b0;
            unique case (avs_address)
                mdt_pkg::OFS_CTRL: rdata_q <= {30'h0000_0000, ctrl_q};
                mdt_pkg::OFS_STATUS: rdata_q <= {16'h0000, wdt_q, 1'b0, sleep_q, gie_q, to_q, pd_q, z_q, dc_q, c_q};
                mdt_pkg::OFS_ACC: rdata_q <= {24'h00_0000, acc_q};
                mdt_pkg::OFS_PC: rdata_q <= {22'h00_0000, pc_q};
                mdt_pkg::OFS_TIMER: rdata_q <= {24'h00_0000, timer_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            wait_q <= 1'b1;
        end
    end

    // control register write, taken at the completing edge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_q <= mdt_pkg::CTRL_RESET;
        end else if (!wait_q && avs_write && avs_address == mdt_pkg::OFS_CTRL && avs_byteenable[0]) begin
            ctrl_q <= avs_writedata[1:0];
        end
    end

    // outputs straight from flip-flops
    assign instr_addr = pc_q;
    assign port5_out = file_q[mdt_pkg::RA_PORT5];
    assign port6_out = file_q[mdt_pkg::RA_PORT6];
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
endmodule

/* File: mdt_core_sva.sv */
// assertion checker watching the decode core ports
`timescale 1ns/10ps
module mdt_core_sva (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // fetch and port registers
    input wire logic [9:0] instr_addr,
    input wire logic [12:0] instr_data,
    input wire logic [7:0] port5_out,
    input wire logic [7:0] port6_out,
    // avalon slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    // one clock domain
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // a taken request is answered in the next cycle
    chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in one cycle");
    // the answer lasts one cycle only
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    // no answer without a request
    chk_wait_idle: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without request");
    // read data hold between answers
    chk_rdata_hold: assert property (avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
        else $error("read data moved while idle");
    // unmapped places read as zero
    chk_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address > 5'h14
        |=> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
    // program counter read matches fetch address
    chk_pc_read: assert property (avs_read && avs_waitrequest && avs_address == mdt_pkg::OFS_PC
        |=> avs_readdata == {22'h00_0000, $past(instr_addr)}) else $error("pc read wrong");
    // an instruction cycle spans at least two clocks
    chk_pc_hold: assert property ($changed(instr_addr) |=> $stable(instr_addr))
        else $error("fetch address changed too soon");
    // port registers move only when an instruction executes
    chk_port_exec: assert property ($changed(port5_out) || $changed(port6_out) |-> $changed(instr_addr))
        else $error("port changed outside execution");
endmodule
bind mdt_core mdt_core_sva i_sva (.mclk, .rst_n, .instr_addr, .instr_data, .port5_out, .port6_out,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);

/* File: mdt_pkg.sv */
// constants, opcodes and register map for the instruction decode and timing block
package mdt_pkg;
    // instruction word layout
    localparam int INSTR_W = 13;
    localparam int PC_W = 10;
    localparam int RADDR_W = 6;
    localparam int STACK_D = 8;
    localparam int FILE_D = 128;
    // special register addresses in the register file
    localparam logic [5:0] RA_INDIRECT = 6'h00;
    localparam logic [5:0] RA_TIMER = 6'h01;
    localparam logic [5:0] RA_PC = 6'h02;
    localparam logic [5:0] RA_STATUS = 6'h03;
    localparam logic [5:0] RA_BANK = 6'h04;
    localparam logic [5:0] RA_BANKED_BASE = 6'h10;
    localparam logic [5:0] RA_PORT5 = 6'h05;
    localparam logic [5:0] RA_PORT6 = 6'h06;
    // field positions in the status register
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_PD = 3;
    localparam int ST_TO = 4;
    // bank select bit in the bank register
    localparam int BANK_BIT = 6;
    // control instruction codes in the low six bits
    localparam logic [5:0] CI_SLEEP = 6'h03;
    localparam logic [5:0] CI_WDTC = 6'h04;
    localparam logic [5:0] CI_IRQ_ON = 6'h10;
    localparam logic [5:0] CI_IRQ_OFF = 6'h11;
    localparam logic [5:0] CI_RET = 6'h12;
    localparam logic [5:0] CI_RETURN_FROM_INTERRUPT_INSTR = 6'h13;
    localparam logic [5:0] CI_CTRL_RD_FIRST = 6'h15;
    localparam logic [5:0] CI_CTRL_WR_FIRST = 6'h05;
    localparam logic [3:0] BANK_SUBCODE = 4'h9;
    // phase counts for the instruction cycle
    localparam logic [1:0] PH_LAST_2 = 2'h1;
    localparam logic [1:0] PH_LAST_4 = 2'h3;
    // avalon register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_ACC = 5'h08;
    localparam logic [4:0] OFS_PC = 5'h0C;
    localparam logic [4:0] OFS_TIMER = 5'h10;
    localparam logic [4:0] OFS_WAKE = 5'h14;
    // control register bits
    localparam int CTRL_RUN = 0;
    localparam int CTRL_CLK4 = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // status register bits seen over the bus
    localparam int BS_GIE = 5;
    localparam int BS_SLEEP = 6;
    localparam int BS_WDT_LSB = 8;
    // alu operations
    typedef enum logic [3:0] {
        MDT_AOP_PASS_A = 4'b0000,
        MDT_AOP_PASS_B = 4'b0001,
        MDT_AOP_ZERO = 4'b0010,
        MDT_AOP_OR = 4'b0011,
        MDT_AOP_AND = 4'b0100,
        MDT_AOP_XOR = 4'b0101,
        MDT_AOP_ADD = 4'b0110,
        MDT_AOP_SUB = 4'b0111,
        MDT_AOP_DEC = 4'b1000
    } mdt_aop_t;
endpackage

/* File: mdt_prog_mem.sv */
// program memory model feeding the decode core
`timescale 1ns/10ps
module mdt_prog_mem (
    // fetch address from the core
    input wire logic [9:0] instr_addr,
    // instruction word back
    output logic [12:0] instr_data
);
    // fixed test program of 13-bit words, answered at once
    always_comb begin
        case (instr_addr)
            10'h000: instr_data = 13'h185A; // literal to accumulator
            10'h001: instr_data = 13'h0045; // accumulator to port 5
            10'h002: instr_data = 13'h0305; // xor with port 5, zero result
            10'h003: instr_data = 13'h0AC6; // set bit 3 of port 6
            10'h004: instr_data = 13'h1808; // jump target to accumulator
            10'h005: instr_data = 13'h0042; // accumulator to program counter
            10'h008: instr_data = 13'h0010; // interrupts on
            10'h009: instr_data = 13'h1010; // call 0x010
            10'h00A: instr_data = 13'h0003; // sleep
            10'h010: instr_data = 13'h1FF8; // add literal, zero result with both carries
            10'h011: instr_data = 13'h0013; // interrupt return to 0x00A
            default: instr_data = 13'h0000; // no operation
        endcase
    end
endmodule
